// ==== shared/acc_pkg.sv ====
package acc_pkg;

	// APB address width and register byte addresses.
	localparam int unsigned ADDR_W     = 20;
	localparam logic [19:0] ADDR_PCE   = 20'hF00F0; // peripheral_clock_enable
	localparam logic [19:0] ADDR_MODE  = 20'hFFF60; // comparator_mode_setting
	localparam logic [19:0] ADDR_FILT  = 20'hFFF64; // comparator_filter_control
	localparam logic [19:0] ADDR_OUTC  = 20'hFFF68; // comparator_output_control
	localparam logic [19:0] ADDR_ISTAT = 20'hFFF6C; // interrupt status, write one to clear
	localparam logic [19:0] ADDR_IMASK = 20'hFFF70; // interrupt mask, one lets the event through

	// Values after reset.
	localparam logic [7:0] PCE_RST   = 8'h00;
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] FILT_RST  = 8'h00;
	localparam logic [7:0] OUTC_RST  = 8'h00;
	localparam logic [1:0] IRQ_RST   = 2'h0;
	localparam logic [4:0] DIV_RST   = 5'h00;

	// Field positions; channel 1 fields sit CH_SHIFT bits above channel 0.
	localparam int unsigned PCE_COMPARATOR_CLOCK_ENABLE = 6;
	localparam int unsigned CH_SHIFT  = 4;
	localparam int unsigned MODE_ENB  = 0;
	localparam int unsigned MODE_VRF  = 2;
	localparam int unsigned MODE_MON  = 3;
	localparam int unsigned FILT_FCK  = 0;
	localparam int unsigned FILT_EPO  = 2;
	localparam int unsigned FILT_EDG  = 3;
	localparam int unsigned OUTC_OE   = 0;
	localparam int unsigned OUTC_INV  = 1;
	localparam int unsigned OUTC_SPD  = 2;

	// Bits that software may change; the rest are stored as zero, and read zero except mode bits 7 and 3, which read the result flags.
	localparam logic [7:0] MODE_WMASK = 8'h55;
	localparam logic [7:0] OUTC_WMASK = 8'h77;

	// Filter sampling divider terminal counts.
	localparam logic [4:0] DIV8_LAST  = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1F;

	// Filter sampling clock selection.
	typedef enum logic [1:0] {
		FCK_OFF,
		FCK_DIV1,
		FCK_DIV8,
		FCK_DIV32
	} acc_fck_t;

	// Controls handed to the analog comparator core.
	typedef struct packed {
		logic       clk_en;       // Comparator clock supply.
		logic       rst_n;        // Comparator reset, active low.
		logic [1:0] enable;       // Per channel operation enable.
		logic [1:0] ref_internal; // Per channel: 1 internal reference, 0 external pin.
		logic [1:0] high_speed;   // Per channel: 1 fast response, 0 low power.
	} acc_core_t;

endpackage

// ==== rtl/acc_ctrl.sv ====
// Overview of operation
// - Clock-enable bit 6 low stops comparator clock and holds it in reset.
// - With clock-enable low, mode, filter, output registers stay reset; writes ignored.
// - Peripheral enable register sits at F00F0H and resets to 00H.
// - Comparator mode register sits at FFF60H and resets to 00H.
// - Mode bits 7 and 3 are read-only result flags.
// - Result flag reads 1 when input above reference, 0 when below.
// - Reference select 0 routes external pin, 1 internal reference; bits 6 and 2.
// - Enable bit 0 disables, 1 enables a channel; bits 4 and 0.
// - Result flag is meaningful only while its channel is enabled.
// - Selected edge on a channel's output raises that channel's interrupt.
// - Each channel's result drives its output pin, inverted or not.
// - Response speed selectable: fast, or slow with lower power.
// - Digital noise filter with software-selected elimination width.
// - Mode register accepts single-bit and full byte writes.
//
// Local design decision: the APB interface to the registers.
module acc_ctrl
	import acc_pkg::*;
(
	input  wire logic              pclk,                      // Bus and block clock, 50 MHz.
	input  wire logic              presetn,                   // Asynchronous reset, active low.
	input  wire logic              psel,                      // APB select.
	input  wire logic              penable,                   // APB access phase.
	input  wire logic              pwrite,                    // APB direction, 1 write.
	input  wire logic [ADDR_W-1:0] paddr,                     // APB byte address.
	input  wire logic [31:0]       pwdata,                    // APB write data.
	input  wire logic [3:0]        pstrb,                     // APB byte strobes.
	output logic      [31:0]       prdata,                    // APB read data.
	output logic                   pready,                    // APB ready.
	output logic                   pslverr,                   // APB error on unmapped address.
	input  wire logic [1:0]        cmp_result_async,          // Raw comparator outputs, unsynchronised.
	output acc_core_t              core_ctrl,                 // Controls to the analog core.
	output logic      [1:0]        compare_output_pin,        // Comparator output pin levels.
	output logic      [1:0]        compare_output_pin_oe,     // Output pin drive enables.
	output logic      [1:0]        compare_edge_interrupt,    // One-cycle pulse per detected edge.
	output logic                   irq                        // Level interrupt, unmasked status set.
);

	// Position of a per-channel field.
	function automatic int unsigned fld(input int unsigned base, input int unsigned ch);
		return base + CH_SHIFT * ch;
	endfunction

	// Address match for one register.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic [7:0]  pce_reg, pce_next;
	logic [7:0]  mode_reg, mode_next;
	logic [7:0]  filt_reg, filt_next;
	logic [7:0]  outc_reg, outc_next;
	logic [1:0]  ist_reg, ist_next;
	logic [1:0]  imsk_reg, imsk_next;
	logic        irq_reg, irq_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic [1:0]  sync1_reg, sync2_reg;
	logic [1:0]  hist_reg [2];
	logic [1:0]  hist_next [2];
	logic [1:0]  flt_reg, flt_next;
	logic [1:0]  edge_reg, edge_next;
	logic [1:0]  pin_reg, pin_next;
	logic [1:0]  pin_oe_reg, pin_oe_next;
	logic [4:0]  div_reg, div_next;
	acc_core_t   core_reg, core_next;
	logic        blk_en;
	logic [1:0]  active;
	logic [1:0]  evt;
	logic [1:0]  tick;
	logic        setup;
	logic        wr;
	logic        mapped;
	logic [31:0] rd_word;
	logic [7:0]  mode_rd;

	assign blk_en = pce_reg[PCE_COMPARATOR_CLOCK_ENABLE];
	assign setup  = psel & ~penable;
	// A write lands only at the edge where the master sees ready in the access phase.
	assign wr     = psel & penable & pwrite & pready_reg & pstrb[0];

	// Read view of the mode register: result flags forced to zero for a stopped channel.
	always_comb begin
		mode_rd = mode_reg;
		for (int unsigned ch = 0; ch < 2; ch++) begin
			mode_rd[fld(MODE_MON, ch)] = flt_reg[ch] & active[ch];
		end
	end

	// Address decode for reads; unmapped addresses read zero and flag an error.
	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		if (hit(paddr, ADDR_PCE)) begin
			rd_word[7:0] = pce_reg;
		end else if (hit(paddr, ADDR_MODE)) begin
			rd_word[7:0] = mode_rd;
		end else if (hit(paddr, ADDR_FILT)) begin
			rd_word[7:0] = filt_reg;
		end else if (hit(paddr, ADDR_OUTC)) begin
			rd_word[7:0] = outc_reg;
		end else if (hit(paddr, ADDR_ISTAT)) begin
			rd_word[1:0] = ist_reg;
		end else if (hit(paddr, ADDR_IMASK)) begin
			rd_word[1:0] = imsk_reg;
		end else begin
			mapped = 1'b0;
		end
	end

	// Bus answer: data is captured in the setup cycle so the access phase never waits.
	always_comb begin
		pready_next  = setup;
		pslverr_next = setup & ~mapped;
		prdata_next  = prdata_reg;
		if (setup) begin
			prdata_next = pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	// Software registers. Comparator registers are pinned to reset while the clock is off.
	always_comb begin
		pce_next  = pce_reg;
		mode_next = mode_reg;
		filt_next = filt_reg;
		outc_next = outc_reg;
		imsk_next = imsk_reg;
		ist_next  = ist_reg;
		if (wr && hit(paddr, ADDR_PCE)) begin
			pce_next = pwdata[7:0];
		end
		if (!blk_en) begin
			mode_next = MODE_RST;
			filt_next = FILT_RST;
			outc_next = OUTC_RST;
		end else if (wr) begin
			if (hit(paddr, ADDR_MODE)) begin
				mode_next = pwdata[7:0] & MODE_WMASK;
			end else if (hit(paddr, ADDR_FILT)) begin
				filt_next = pwdata[7:0];
			end else if (hit(paddr, ADDR_OUTC)) begin
				outc_next = pwdata[7:0] & OUTC_WMASK;
			end
		end
		if (wr && hit(paddr, ADDR_IMASK)) begin
			imsk_next = pwdata[1:0];
		end
		if (wr && hit(paddr, ADDR_ISTAT)) begin
			ist_next = ist_reg & ~pwdata[1:0];
		end
		// A new event in the clearing cycle wins over the clear.
		ist_next = ist_next | evt;
		irq_next = |(ist_next & imsk_next);
	end

	// Filter sampling divider: free running so every setting has a steady sample rate.
	always_comb begin
		// The divider wraps on purpose, so the carry out of the top bit is dropped.
		div_next = 5'(div_reg + 5'h01);
		for (int unsigned ch = 0; ch < 2; ch++) begin
			case (acc_fck_t'(filt_reg[fld(FILT_FCK, ch) +: 2]))
				FCK_DIV1:  tick[ch] = 1'b1;
				FCK_DIV8:  tick[ch] = div_reg[2:0] == DIV8_LAST[2:0];
				FCK_DIV32: tick[ch] = div_reg == DIV32_LAST;
				default:   tick[ch] = 1'b0;
			endcase
		end
	end

	// Per-channel filter, edge detection, pin drive and core controls.
	always_comb begin
		core_next.clk_en = blk_en;
		core_next.rst_n  = blk_en;
		for (int unsigned ch = 0; ch < 2; ch++) begin
			active[ch]                 = blk_en & mode_reg[fld(MODE_ENB, ch)];
			core_next.enable[ch]       = active[ch];
			core_next.ref_internal[ch] = mode_reg[fld(MODE_VRF, ch)];
			core_next.high_speed[ch]   = outc_reg[fld(OUTC_SPD, ch)];
			hist_next[ch]              = hist_reg[ch];
			flt_next[ch]               = flt_reg[ch];
			if (!active[ch]) begin
				// A stopped channel tracks its input so enabling it fakes no edge.
				hist_next[ch] = {2{sync2_reg[ch]}};
				flt_next[ch]  = sync2_reg[ch];
			end else if (acc_fck_t'(filt_reg[fld(FILT_FCK, ch) +: 2]) == FCK_OFF) begin
				hist_next[ch] = {2{sync2_reg[ch]}};
				flt_next[ch]  = sync2_reg[ch];
			end else if (tick[ch]) begin
				// Three equal samples in a row are needed before the output moves.
				hist_next[ch] = {hist_reg[ch][0], sync2_reg[ch]};
				if (sync2_reg[ch] == hist_reg[ch][0] && sync2_reg[ch] == hist_reg[ch][1]) begin
					flt_next[ch] = sync2_reg[ch];
				end
			end
			if (!active[ch] || flt_next[ch] == flt_reg[ch]) begin
				evt[ch] = 1'b0;
			end else if (filt_reg[fld(FILT_EDG, ch)]) begin
				evt[ch] = 1'b1;
			end else begin
				evt[ch] = flt_next[ch] ^ filt_reg[fld(FILT_EPO, ch)];
			end
			edge_next[ch]   = evt[ch];
			pin_next[ch]    = flt_next[ch] ^ outc_reg[fld(OUTC_INV, ch)];
			pin_oe_next[ch] = active[ch] & outc_reg[fld(OUTC_OE, ch)];
		end
	end

	// Two-flop synchroniser; only the second stage feeds any logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end else begin
			sync1_reg <= cmp_result_async;
			sync2_reg <= sync1_reg;
		end
	end

	// State registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pce_reg     <= PCE_RST;
			mode_reg    <= MODE_RST;
			filt_reg    <= FILT_RST;
			outc_reg    <= OUTC_RST;
			ist_reg     <= IRQ_RST;
			imsk_reg    <= IRQ_RST;
			irq_reg     <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			hist_reg[0] <= 2'h0;
			hist_reg[1] <= 2'h0;
			flt_reg     <= 2'h0;
			edge_reg    <= 2'h0;
			pin_reg     <= 2'h0;
			pin_oe_reg  <= 2'h0;
			div_reg     <= DIV_RST;
			core_reg    <= '0;
		end else begin
			pce_reg     <= pce_next;
			mode_reg    <= mode_next;
			filt_reg    <= filt_next;
			outc_reg    <= outc_next;
			ist_reg     <= ist_next;
			imsk_reg    <= imsk_next;
			irq_reg     <= irq_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			hist_reg[0] <= hist_next[0];
			hist_reg[1] <= hist_next[1];
			flt_reg     <= flt_next;
			edge_reg    <= edge_next;
			pin_reg     <= pin_next;
			pin_oe_reg  <= pin_oe_next;
			div_reg     <= div_next;
			core_reg    <= core_next;
		end
	end

	// Every output leaves straight from a flip-flop.
	assign prdata                 = prdata_reg;
	assign pready                 = pready_reg;
	assign pslverr                = pslverr_reg;
	assign core_ctrl              = core_reg;
	assign compare_output_pin     = pin_reg;
	assign compare_output_pin_oe  = pin_oe_reg;
	assign compare_edge_interrupt = edge_reg;
	assign irq                    = irq_reg;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Bus steps used by several checks.
	sequence s_wr(logic [ADDR_W-1:0] off);
		psel && penable && pwrite && pready_reg && pstrb[0] && paddr == off;
	endsequence

	sequence s_rd_setup(logic [ADDR_W-1:0] off);
		psel && !penable && !pwrite && paddr == off;
	endsequence

	// Core clock and reset follow the enable bit one cycle later.
	a_core_clk_gate: assert property (1'b1 |=> core_reg.clk_en == $past(pce_reg[PCE_COMPARATOR_CLOCK_ENABLE])
		&& core_reg.rst_n == $past(pce_reg[PCE_COMPARATOR_CLOCK_ENABLE]))
		else $error("comparator clock or reset does not follow enable bit");

	// Stopped block keeps its comparator registers at reset even when written.
	a_hold_when_off: assert property (!blk_en |=> mode_reg == MODE_RST && filt_reg == FILT_RST
		&& outc_reg == OUTC_RST)
		else $error("comparator register changed while clock disabled");

	a_pce_write: assert property (s_wr(ADDR_PCE) |=> pce_reg == $past(pwdata[7:0]))
		else $error("peripheral enable write not stored");

	a_mode_write: assert property (blk_en ##0 s_wr(ADDR_MODE) |=> mode_reg == ($past(pwdata[7:0]) & MODE_WMASK))
		else $error("mode write not stored with read-only bits masked");

	// Reserved mode bits read zero; result flags report the filtered comparison.
	a_mode_readback: assert property (s_rd_setup(ADDR_MODE) |=> prdata[5] == 1'b0 && prdata[1] == 1'b0
		&& prdata[7] == $past(flt_reg[1] & active[1]) && prdata[3] == $past(flt_reg[0] & active[0]))
		else $error("mode readback wrong");

	a_ref_route: assert property (1'b1 |=> core_reg.ref_internal == {$past(mode_reg[6]), $past(mode_reg[2])})
		else $error("reference select not routed");

	a_enable_route: assert property (1'b1 |=> core_reg.enable == $past(active)
		&& core_reg.high_speed == {$past(outc_reg[6]), $past(outc_reg[2])})
		else $error("channel enable or speed not routed");

	// Per-channel checks of filter, edge and pin behaviour.
	for (genvar g = 0; g < 2; g++) begin : g_chk
		a_edge_sets_flag: assert property (evt[g] |=> ist_reg[g] && edge_reg[g] && (irq_reg || !imsk_reg[g]))
			else $error("edge did not set status and pulse");

		a_pin_drive: assert property (1'b1 |=> pin_reg[g] == ($past(flt_next[g]) ^ $past(outc_reg[fld(OUTC_INV, g)])))
			else $error("output pin level wrong");

		a_filter_hold: assert property (active[g] && filt_reg[fld(FILT_FCK, g) +: 2] != 2'h0
			&& (!tick[g] || sync2_reg[g] != hist_reg[g][0]) |=> $stable(flt_reg[g]))
			else $error("filter output moved without three equal samples");

		a_sync_latency: assert property ((active[g] && filt_reg[fld(FILT_FCK, g) +: 2] == 2'h0)[*4]
			|-> flt_reg[g] == $past(cmp_result_async[g], 3))
			else $error("unfiltered result not three cycles behind raw input");
	end

endmodule

// ==== tb/acc_analog_model.sv ====
module acc_analog_model
	import acc_pkg::*;
#(
	parameter logic [9:0] INT_REF = 10'h32F // Internal reference in millivolts.
)
(
	input  wire logic            pclk,      // Bench clock, drives the idle pattern.
	input  acc_core_t            core_ctrl, // Controls from the block.
	input  wire logic [1:0][9:0] vin,       // Analog input level per channel.
	input  wire logic [1:0][9:0] vext,      // External reference level per channel.
	output logic      [1:0]      cmp_out    // Raw comparison result per channel.
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] idle_pat = 2'h1;

	// A stopped comparator gives no usable level, so it shows a toggling pattern instead of a stale value.
	always @(posedge pclk) begin
		idle_pat <= ~idle_pat;
	end

	// Each channel compares only while clocked, out of reset and enabled.
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			if (core_ctrl.clk_en && core_ctrl.rst_n && core_ctrl.enable[c]) begin
				cmp_out[c] = vin[c] > (core_ctrl.ref_internal[c] ? INT_REF : vext[c]);
			end else begin
				cmp_out[c] = idle_pat[c];
			end
		end
	end
endmodule

// ==== tb/testbench.sv ====
module testbench
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [9:0] INT_REF = 10'h32F;

	logic            pclk = 1'b0;
	logic            presetn = 1'b0;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic [19:0]     paddr;
	logic [31:0]     pwdata;
	logic [3:0]      pstrb;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic            irq;
	logic [1:0]      cmp_raw;
	logic [1:0]      pin;
	logic [1:0]      pin_oe;
	logic [1:0]      edge_irq;
	acc_core_t       core;
	logic [1:0][9:0] vin;
	logic [1:0][9:0] vext;
	logic [32:0]     exp_q[$];
	int              fail_count = 0;
	int              checks = 0;

	always #10 pclk = ~pclk;

	acc_ctrl acc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_result_async(cmp_raw), .core_ctrl(core), .compare_output_pin(pin),
		.compare_output_pin_oe(pin_oe), .compare_edge_interrupt(edge_irq), .irq(irq));

	acc_analog_model #(.INT_REF(INT_REF)) acc_analog_model_i (.pclk(pclk), .core_ctrl(core), .vin(vin),
		.vext(vext), .cmp_out(cmp_raw));

	task automatic complete_run();
		if (fail_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; a read notes its expected {error, data} for the watcher.
	task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d, input logic [32:0] e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		pstrb   <= 4'hF;
		if (!w) begin
			exp_q.push_back(e);
		end
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				break;
			end
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 16) begin
			fail_count++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [19:0] a, input logic [7:0] d);
		apb(1'b0, a, 8'h00, {25'h0, d});
	endtask

	// Monitor flags follow the inputs only on enabled channels; bits 5 and 1 stay zero.
	function automatic logic [7:0] exp_mode(input logic [7:0] m);
		logic [7:0] w;
		w = m & 8'h55;
		for (int c = 0; c < 2; c++) begin
			w[4*c+3] = w[4*c] && (vin[c] > (w[4*c+2] ? INT_REF : vext[c]));
		end
		return w;
	endfunction

	// Each completed read takes the oldest note off the queue.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			check({pslverr, prdata}, exp_q.pop_front());
		end
	end

	initial begin
		#100000;
		fail_count++;
		complete_run();
	end

	initial begin
		int         n;
		logic [7:0] m;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		vin  = '0;
		vext = '0;
		void'($urandom(11633));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_PCE, PCE_RST);
		rd(ADDR_MODE, MODE_RST);
		wr(ADDR_MODE, 8'h11);
		rd(ADDR_MODE, 8'h00);
		apb(1'b0, 20'h00004, 8'h00, {1'b1, 32'h0});
		check({25'h0, core}, 33'h0);
		wr(ADDR_PCE, 8'h40);
		rd(ADDR_PCE, 8'h40);
		idle(1);
		check({31'h0, core.clk_en, core.rst_n}, 33'h3);
		// Even inputs against odd references keep every comparison strict.
		repeat (16) begin
			vin  <= {10'(2 * $urandom_range(500)), 10'(2 * $urandom_range(500))};
			vext <= {10'(2 * $urandom_range(500) + 1), 10'(2 * $urandom_range(500) + 1)};
			m = 8'($urandom);
			wr(ADDR_MODE, m);
			idle(4);
			rd(ADDR_MODE, exp_mode(m));
			check({29'h0, core.enable, core.ref_internal}, {29'h0, m[4], m[0], m[6], m[2]});
		end
		vext <= {10'h1F5, 10'h1F5};
		vin  <= '0;
		wr(ADDR_MODE, 8'h01);
		wr(ADDR_ISTAT, 8'h03);
		wr(ADDR_IMASK, 8'h01);
		vin[0] <= 10'h384;
		for (n = 0; n < 10 && edge_irq[0] !== 1'b1; n++) begin
			@(posedge pclk);
		end
		// A pulse that never came uses up the loop and is counted here.
		check({32'h0, edge_irq[0]}, 33'h1);
		check({32'h0, irq}, 33'h1);
		rd(ADDR_ISTAT, 8'h01);
		wr(ADDR_ISTAT, 8'h01);
		idle(1);
		check({32'h0, irq}, 33'h0);
		vin[0] <= 10'h000;
		idle(5);
		rd(ADDR_ISTAT, 8'h00);
		wr(ADDR_FILT, 8'h04);
		vin[0] <= 10'h384;
		idle(5);
		rd(ADDR_ISTAT, 8'h00);
		vin[0] <= 10'h000;
		idle(5);
		rd(ADDR_ISTAT, 8'h01);
		wr(ADDR_IMASK, 8'h00);
		idle(1);
		check({32'h0, irq}, 33'h0);
		wr(ADDR_OUTC, 8'h03);
		idle(2);
		check({31'h0, pin_oe[0], pin[0]}, 33'h3);
		wr(ADDR_OUTC, 8'h05);
		idle(2);
		check({30'h0, pin_oe[0], pin[0], core.high_speed[0]}, 33'h5);
		// A slow sampling filter must hide a fresh change until three samples agree.
		wr(ADDR_FILT, 8'h03);
		vin[0] <= 10'h384;
		idle(4);
		rd(ADDR_MODE, 8'h01);
		idle(100);
		rd(ADDR_MODE, 8'h09);
		wr(ADDR_PCE, 8'h00);
		// The output register clears one edge after the enable, and the core word one edge after that.
		idle(3);
		check({25'h0, core}, 33'h0);
		rd(ADDR_MODE, 8'h00);
		rd(ADDR_OUTC, 8'h00);
		idle(2);
		complete_run();
	end
endmodule
